// >>> hdl/tx_unpack_cfg.svh
`ifndef TX_UNPACK_CFG_SVH
`define TX_UNPACK_CFG_SVH

// Register byte offsets
`define OFS_DATA 8'h00
`define OFS_STATUS 8'h04
`define OFS_CFG 8'h08
`define OFS_INFO 8'h0C

// Configuration register
`define CFG_SAO_BIT 0
`define CFG_DEFER_BIT 1
`define CFG_RESET 2'h0

// Info register
`define INFO_ERR_BIT 8
`define INFO_FULL_BIT 9
`define INFO_BUSY_BIT 16

// First command word fields
`define CMDA_ALIGN_HI 25
`define CMDA_ALIGN_LO 24
`define CMDA_OFS_HI 20
`define CMDA_OFS_LO 16
`define CMDA_FIRST_BIT 13
`define CMDA_LAST_BIT 12
`define CMD_SIZE_HI 10

// Second command word tag field
`define CMDB_TAG_HI 31
`define CMDB_TAG_LO 16

// End alignment codes
`define ALIGN_4 2'h0
`define ALIGN_16 2'h1
`define ALIGN_32 2'h2
`define MASK_4 12'h003
`define MASK_16 12'h00F
`define MASK_32 12'h01F

// Status FIFO geometry
`define STS_DEPTH_LOG2 4
`define STS_DEPTH 5'h10

`endif

// >>> hdl/tx_unpack_pkg.sv
package tx_unpack_pkg;

  typedef enum logic [1:0] {
    st_cmd_a,
    st_cmd_b,
    st_data
  } unpack_state_e;

  typedef logic [31:0] word_t;

endpackage : tx_unpack_pkg

// >>> hdl/status_fifo_mem.sv
`timescale 1ns/10ps
`include "tx_unpack_cfg.svh"

module status_fifo_mem import tx_unpack_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [`STS_DEPTH_LOG2-1:0] wr_addr,
  input wire word_t wr_data,
  input wire logic [`STS_DEPTH_LOG2-1:0] rd_addr,
  output word_t rd_data
);

  word_t mem [0:(1<<`STS_DEPTH_LOG2)-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : status_fifo_mem

// >>> hdl/tx_unpack.sv
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "tx_unpack_cfg.svh"

module tx_unpack import tx_unpack_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic mac_valid,
  output logic [31:0] mac_data,
  output logic [3:0] mac_be,
  output logic mac_last,
  output logic [15:0] mac_tag,
  input wire logic mac_ready,
  output logic tx_enable,
  input wire logic mac_done,
  input wire logic [15:0] mac_done_tag,
  input wire logic mac_lost_carrier,
  input wire logic mac_no_carrier,
  input wire logic mac_late_collision,
  input wire logic mac_excess_collisions,
  input wire logic [3:0] mac_collision_count,
  input wire logic mac_excess_deferral,
  input wire logic mac_deferred,
  output logic transmit_error_flag
);

  function automatic logic [11:0] round_up(input logic [11:0] n, input logic [1:0] code);
    logic [11:0] mask;
    mask = (code == `ALIGN_32) ? `MASK_32 : (code == `ALIGN_16) ? `MASK_16 : `MASK_4;
    round_up = (n + mask) & ~mask;
  endfunction : round_up

  // Bus data-phase tracking
  logic pend;
  logic p_write;
  logic [7:0] p_addr;

  // Configuration
  logic status_discard_allow_overrun;
  logic defer_check;

  // Unpacker state
  unpack_state_e st;
  logic [4:0] ofs;
  logic [10:0] size;
  logic first_segment;
  logic last_segment;
  logic [9:0] words;
  logic [9:0] idx;
  logic [15:0] tag;

  // Status FIFO state
  logic [`STS_DEPTH_LOG2:0] wr_ptr;
  logic [`STS_DEPTH_LOG2:0] rd_ptr;
  logic ovr_lock;
  word_t rd_word;
  logic sts_fresh;

  wire take = hsel & htrans[1] & hready;
  wire sel_data = (p_addr == `OFS_DATA);
  wire sel_status = (p_addr == `OFS_STATUS);
  wire sel_cfg = (p_addr == `OFS_CFG);
  wire sel_info = (p_addr == `OFS_INFO);

  // Byte window of current buffer
  wire [11:0] buf_start = {7'h00, ofs};
  wire [11:0] buf_end = buf_start + {1'b0, size};
  wire [11:0] wbase = {idx, 2'b00};
  wire [3:0] lane_be;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      wire [11:0] bpos = wbase + 12'(g);
      assign lane_be[g] = (bpos >= buf_start) && (bpos < buf_end);
    end
  endgenerate

  wire data_wr = pend & p_write & sel_data;
  wire emit = (st == st_data) && (lane_be != 4'h0);
  // Data phase of a payload-word write waits while the offered word is unaccepted
  wire stall = data_wr & emit & mac_valid & ~mac_ready;
  wire done_now = pend & ~stall;
  wire wr_done = done_now & p_write;
  wire rd_done = done_now & ~p_write;
  wire accept = data_wr & done_now;
  wire word_last = (wbase + 12'h004) >= buf_end;

  wire [11:0] cmd_end = {7'h00, hwdata[`CMDA_OFS_HI:`CMDA_OFS_LO]}
                      + {1'b0, hwdata[`CMD_SIZE_HI:0]};
  wire [11:0] cmd_span = round_up(cmd_end, hwdata[`CMDA_ALIGN_HI:`CMDA_ALIGN_LO]);
  wire [9:0] cmd_words = cmd_span[11:2];

  // Status word assembly
  // excess deferral gated by defer_check; mac_deferred passes ungated
  wire defer_x = mac_excess_deferral & defer_check;
  wire error_summary = mac_lost_carrier | mac_no_carrier | mac_late_collision
                     | mac_excess_collisions | defer_x;
  wire [3:0] coll = mac_excess_collisions ? 4'h0 : mac_collision_count;
  wire word_t sts_word = {mac_done_tag, error_summary, 3'h0, mac_lost_carrier,
                          mac_no_carrier, mac_late_collision, mac_excess_collisions,
                          1'b0, coll, defer_x, 1'b0, mac_deferred};

  wire [`STS_DEPTH_LOG2:0] count = wr_ptr - rd_ptr;
  wire full = (count == `STS_DEPTH);
  wire empty = (count == 5'h00);
  // Read port lags a write into the head slot by one cycle
  wire sts_none = empty | sts_fresh;
  wire pop = rd_done & sel_status & ~sts_none;
  wire push = mac_done & ~full & ~ovr_lock;
  wire overrun = mac_done & (full | ovr_lock);
  wire err_set = overrun & ~status_discard_allow_overrun;
  wire err_clr = wr_done & sel_info & hwdata[`INFO_ERR_BIT];
  wire [`STS_DEPTH_LOG2:0] next_count = count + {4'h0, push} - {4'h0, pop};
  wire [`STS_DEPTH_LOG2:0] used_shown = ovr_lock ? 5'h00 : count;
  wire [31:0] info_word = {15'h0000, st != st_cmd_a, 6'h00, full,
                           transmit_error_flag, 3'h0, used_shown};
  wire [31:0] read_mux = sel_status ? (sts_none ? 32'h0000_0000 : rd_word)
                       : sel_cfg ? {30'h0, defer_check, status_discard_allow_overrun}
                       : sel_info ? info_word
                       : 32'h0000_0000;

  status_fifo_mem u_sts (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(push),
    .wr_addr(wr_ptr[`STS_DEPTH_LOG2-1:0]),
    .wr_data(sts_word),
    .rd_addr(rd_ptr[`STS_DEPTH_LOG2-1:0]),
    .rd_data(rd_word)
  );

  // Bus slave: one wait state minimum
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= 1'b0;
      p_write <= 1'b0;
      p_addr <= 8'h00;
      hreadyout <= 1'b1;
    end else if (take) begin
      pend <= 1'b1;
      p_write <= hwrite;
      p_addr <= haddr[7:0];
      hreadyout <= 1'b0;
    end else if (done_now) begin
      pend <= 1'b0;
      hreadyout <= 1'b1;
    end
  end

  // Every transfer answers OKAY
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_done) begin
      hrdata <= read_mux;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_discard_allow_overrun <= 1'b0;
      defer_check <= 1'b0;
    end else if (wr_done & sel_cfg) begin
      status_discard_allow_overrun <= hwdata[`CFG_SAO_BIT];
      defer_check <= hwdata[`CFG_DEFER_BIT];
    end
  end

  // Unpacker sequencing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= st_cmd_a;
      ofs <= 5'h00;
      size <= 11'h000;
      first_segment <= 1'b0;
      last_segment <= 1'b0;
      words <= 10'h000;
      idx <= 10'h000;
      tag <= 16'h0000;
    end else if (accept) begin
      case (st)
        st_cmd_a: begin
          ofs <= hwdata[`CMDA_OFS_HI:`CMDA_OFS_LO];
          size <= hwdata[`CMD_SIZE_HI:0];
          first_segment <= hwdata[`CMDA_FIRST_BIT];
          last_segment <= hwdata[`CMDA_LAST_BIT];
          words <= cmd_words;
          idx <= 10'h000;
          st <= st_cmd_b;
        end
        st_cmd_b: begin
          if (first_segment) begin
            tag <= hwdata[`CMDB_TAG_HI:`CMDB_TAG_LO];
          end
          st <= (words == 10'h000) ? st_cmd_a : st_data;
        end
        st_data: begin
          idx <= idx + 10'h001;
          if (idx == words - 10'h001) begin
            st <= st_cmd_a;
          end
        end
        default: begin
          st <= st_cmd_a;
        end
      endcase
    end
  end

  // Word hand-off to MAC FIFO
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mac_valid <= 1'b0;
    end else if (accept & emit) begin
      mac_valid <= 1'b1;
    end else if (mac_ready) begin
      mac_valid <= 1'b0;
    end
  end

  // Payload only moves when a new word is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mac_data <= 32'h0000_0000;
      mac_be <= 4'h0;
      mac_last <= 1'b0;
      mac_tag <= 16'h0000;
    end else if (accept & emit) begin
      mac_data <= hwdata;
      mac_be <= lane_be;
      mac_last <= last_segment & word_last;
      mac_tag <= tag;
    end
  end

  // Status FIFO pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= 5'h00;
      rd_ptr <= 5'h00;
      sts_fresh <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 5'h01;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 5'h01;
      end
      // Push into empty FIFO lands on head slot
      sts_fresh <= push & empty;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovr_lock <= 1'b0;
    end else if (overrun & status_discard_allow_overrun) begin
      ovr_lock <= 1'b1;
    end else if (pop) begin
      ovr_lock <= 1'b0;
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_error_flag <= 1'b0;
    end else begin
      transmit_error_flag <= err_set | (transmit_error_flag & ~err_clr);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_enable <= 1'b1;
    end else begin
      // Next count, so suspension lands with the push
      tx_enable <= status_discard_allow_overrun | (next_count != `STS_DEPTH);
    end
  end

endmodule : tx_unpack

// >>> dv/tx_unpack_checker.sv
`timescale 1ns/10ps
module tx_unpack_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic mac_valid,
  input wire logic [31:0] mac_data,
  input wire logic [3:0] mac_be,
  input wire logic mac_last,
  input wire logic [15:0] mac_tag,
  input wire logic mac_ready,
  input wire logic tx_enable,
  input wire logic mac_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  be_nonempty_a:
    assert property (mac_valid |-> mac_be != 4'h0) else $error("empty word offered");
  be_contig_a:
    assert property (mac_valid |-> mac_be inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7,
      4'h8, 4'hC, 4'hE, 4'hF}) else $error("byte lanes not contiguous");
  word_hold_a:
    assert property (mac_valid && !mac_ready |=> mac_valid
      && $stable({mac_data, mac_be, mac_last, mac_tag})) else $error("word dropped");
  word_launch_a:
    assert property ($rose(mac_valid) |-> hreadyout) else $error("word before bus done");
  addr_wait_a:
    assert property (hsel && htrans[1] && hready |=> !hreadyout) else $error("no wait");
  okay_resp_a:
    assert property (hresp == 1'b0) else $error("response not okay");
  full_stop_a:
    assert property ($fell(tx_enable) |-> $past(mac_done) || $past(mac_done, 2))
      else $error("transmit stopped without status");
  phase_end_a:
    assert property (!hreadyout && !mac_valid |=> hreadyout) else $error("bus stalled");
endmodule : tx_unpack_checker
bind tx_unpack tx_unpack_checker tx_unpack_checker_inst (.clk, .rst_n, .hsel, .htrans,
  .hready, .hreadyout, .hresp, .mac_valid, .mac_data, .mac_be, .mac_last, .mac_tag,
  .mac_ready, .tx_enable, .mac_done);

// >>> dv/mac_partner.sv
`timescale 1ns/10ps
module mac_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mac_valid,
  input wire logic mac_last,
  input wire logic [15:0] mac_tag,
  input wire logic tx_enable,
  output logic mac_ready,
  output logic mac_done,
  output logic [15:0] mac_done_tag
);
  logic [15:0] tags[$];
  logic busy;
  logic [15:0] cur_tag;
  // send whole packets in order
  // A frame once begun ends even if tx_enable drops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mac_ready <= 1'b0;
      mac_done <= 1'b0;
      mac_done_tag <= 16'h0;
      busy <= 1'b0;
      cur_tag <= 16'h0;
      tags.delete();
    end else begin
      mac_ready <= ($urandom % 3) != 0;
      if (mac_valid && mac_ready && mac_last) tags.push_back(mac_tag);
      mac_done <= busy;
      mac_done_tag <= busy ? cur_tag : ~mac_done_tag;
      if (!busy && tx_enable && tags.size() > 0) begin
        busy <= 1'b1;
        cur_tag <= tags.pop_front();
      end else begin
        busy <= 1'b0;
      end
    end
  end
endmodule : mac_partner

// >>> dv/tb_tx_unpack.sv
`timescale 1ns/10ps
module tb_tx_unpack;
  logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, mac_valid, mac_last, mac_ready;
  logic tx_enable, mac_done, transmit_error_flag;
  logic [31:0] haddr, hwdata, hrdata, mac_data, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] mac_be, mac_collision_count;
  logic [15:0] mac_tag, mac_done_tag, tg;
  logic [5:0] fl;
  logic [52:0] q[$];
  int fails, n_tests;
  assign hready = hreadyout;
  tx_unpack tx_unpack_inst (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
    .hwdata, .hreadyout, .hresp, .hrdata, .mac_valid, .mac_data, .mac_be, .mac_last,
    .mac_tag, .mac_ready, .tx_enable, .mac_done, .mac_done_tag,
    .mac_lost_carrier(fl[5]), .mac_no_carrier(fl[4]), .mac_late_collision(fl[3]),
    .mac_excess_collisions(fl[2]), .mac_collision_count, .mac_excess_deferral(fl[1]),
    .mac_deferred(fl[0]), .transmit_error_flag);
  mac_partner mac_partner_inst (.clk, .rst_n, .mac_valid, .mac_last, .mac_tag, .tx_enable,
    .mac_ready, .mac_done, .mac_done_tag);
  task cmp(input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (e !== g) begin
      fails++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp
  task wrap_up;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (!hreadyout);
    r = hrdata;
  endtask : bus
  task snd(input logic fs, input logic ls);
    int off, sz, m, n;
    logic [1:0] al;
    logic [31:0] d;
    logic [3:0] be;
    off = $urandom % 32;
    // middle buffers at least four bytes
    sz = (fs || ls) ? 1 + $urandom % 40 : 4 + $urandom % 40;
    al = $urandom % 3;
    m = (al == 2'h0) ? 3 : (al == 2'h1) ? 15 : 31;
    n = ((off + sz + m) & ~m) / 4;
    bus(1'b1, 8'h00, {6'h0, al, 3'h0, off[4:0], 2'h0, fs, ls, 1'h0, sz[10:0]});
    bus(1'b1, 8'h00, {tg, 16'h0});
    for (int i = 0; i < n; i++) begin
      d = $urandom;
      for (int b = 0; b < 4; b++) be[b] = (4 * i + b >= off) && (4 * i + b < off + sz);
      if (be != 4'h0) q.push_back({tg, ls && (4 * i + 4 >= off + sz), be, d});
      bus(1'b1, 8'h00, d);
    end
  endtask : snd
  task wait_used(input logic [4:0] n);
    r = 32'hFFFF_FFFF;
    for (int i = 0; i < 300 && r[4:0] !== n; i++) bus(1'b0, 8'h0C, 32'h0);
    cmp(n, r[4:0]);
  endtask : wait_used
  always @(posedge clk) begin
    if (rst_n && mac_valid && mac_ready) cmp(q.pop_front(),
      {mac_tag, mac_last, mac_be, mac_data});
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500000;
    fails++;
    wrap_up;
  end
  initial begin
    {rst_n, hsel, haddr, htrans, hwrite, hwdata, fl, mac_collision_count, tg} = '0;
    hsize = 3'h2;
    fails = 0;
    n_tests = 0;
    void'($urandom(40));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 8'h08, 32'h0);
    cmp(32'h0, r);
    bus(1'b0, 8'h20, 32'h0);
    cmp(32'h0, r);
    bus(1'b1, 8'h08, 32'h2);
    for (int k = 0; k < 7; k++) begin
      fl <= (k == 0) ? 6'h00 : 6'h01 << (k - 1);
      mac_collision_count <= 4'($urandom);
      tg = $urandom;
      if (k % 2 == 1) begin
        snd(1'b1, 1'b0);
        snd(1'b0, 1'b0);
        snd(1'b0, 1'b1);
      end else snd(1'b1, 1'b1);
      wait_used(5'h01);
      bus(1'b0, 8'h04, 32'h0);
      cmp({tg, |fl[5:1], 3'h0, fl[5:2], 1'h0, fl[2] ? 4'h0 : mac_collision_count, fl[1],
        1'h0, fl[0]}, r);
    end
    fl <= 6'h0;
    repeat (16) snd(1'b1, 1'b1);
    wait_used(5'h10);
    cmp(1'b0, tx_enable);
    // Two packets held; the second is in flight when the FIFO refills
    snd(1'b1, 1'b1);
    snd(1'b1, 1'b1);
    repeat (20) @(posedge clk);
    bus(1'b0, 8'h04, 32'h0);
    cmp({tg, 9'h000, mac_collision_count, 3'h0}, r);
    repeat (100) @(posedge clk);
    bus(1'b0, 8'h0C, 32'h0);
    cmp(6'h30, {r[8], r[4:0]});
    bus(1'b1, 8'h0C, 32'h100);
    bus(1'b0, 8'h0C, 32'h0);
    cmp(6'h10, {r[8], r[4:0]});
    snd(1'b1, 1'b1);
    bus(1'b1, 8'h08, 32'h3);
    repeat (100) @(posedge clk);
    bus(1'b0, 8'h0C, 32'h0);
    cmp(6'h0, {r[8], r[4:0]});
    cmp(64'h0, q.size());
    wrap_up;
  end
endmodule : tb_tx_unpack
